// File: hdl/ascp_pkg.sv
// Package for the serial configuration port of the data converter.
// Assumes a 200 MHz system clock and a byte-addressed Avalon-MM slave.
package ascp_pkg;
	// Clock and link timing
	localparam int CLK_PERIOD_PS = 5000;
	localparam int STRAP_HOLD_NS = 1000;     // Reset held longer means strap
	localparam int STRAP_CYCLES  = (STRAP_HOLD_NS * 1000) / CLK_PERIOD_PS;
	// Serial word layout
	localparam int         WORD_BITS = 16;
	localparam logic [3:0] LAST_BIT  = 4'hF; // Index of sixteenth bit
	localparam logic [3:0] ADDR_DONE = 4'h8; // Bits seen when address is in
	localparam logic [3:0] DATA_FIRST = 4'h9;
	// Configuration register file: addresses and defaults
	localparam logic [7:0] CFG_CTL_ADDR  = 8'h00;
	localparam int         CTL_SWRST_BIT = 1;
	localparam int         CTL_RBACK_BIT = 0;
	localparam logic [7:0] CFG_GAIN_ADDR = 8'h25;
	localparam logic [7:0] CFG_GAIN_DFLT = 8'h50;
	localparam logic [7:0] CFG_CLK_ADDR  = 8'h42;
	localparam logic [7:0] CFG_CLK_DFLT  = 8'h08;
	localparam logic [7:0] CFG_ZERO      = 8'h00;
	// Avalon register map (byte addresses)
	localparam logic [11:0] AV_STATUS  = 12'h000;
	localparam logic [11:0] AV_CTRL    = 12'h004;
	localparam logic [11:0] AV_WORDS   = 12'h008;
	localparam logic [1:0]  AV_CFG_WIN = 2'h1;   // addr[11:10] of window
	localparam int          AV_CTRL_SWRST = 0;
	localparam int          AV_CTRL_PORTEN = 1;
	localparam logic [1:0]  AV_CTRL_RESET = 2'h2;
	// Format pin level codes
	localparam int FMT_LVL_HI = 1;
	localparam int FMT_LVL_LO = 0;
endpackage : ascp_pkg

// File: hdl/ascp_serial_port.sv
// Serial configuration port with register file, readback and strap pins.
// Assumes all pins are asynchronous to clk; the Avalon master runs on clk.
`timescale 1ns/1ps
`default_nettype none
module ascp_serial_port (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic [11:0] avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        serial_enable_n,
	input  wire logic        serial_clk,
	input  wire logic        serial_in_line,
	input  wire logic        reset_pin,
	input  wire logic [1:0]  format_select_pin,
	input  wire logic        output_enable_pin,
	input  wire logic        overrange_in,
	output logic             overrange_or_readback_pin,
	output logic             fmt_offset_binary,
	output logic             fmt_cmos,
	output logic             out_buffers_en,
	output logic             standby
);
	// Pin synchronisers: stage 1 is read by stage 2 only
	logic [6:0] pin_s1_r;
	logic [6:0] pin_s2_r;
	logic       sclk_d_r;
	wire  [6:0] pin_raw = {output_enable_pin, format_select_pin, reset_pin,
	                       serial_in_line, serial_clk, serial_enable_n};
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pin_s1_r <= 7'h01;
			pin_s2_r <= 7'h01;
			sclk_d_r <= 1'b0;
		end else begin
			pin_s1_r <= pin_raw;
			pin_s2_r <= pin_s1_r;
			sclk_d_r <= pin_s2_r[1];
		end
	end
	wire sen_n_s = pin_s2_r[0];
	wire sclk_s  = pin_s2_r[1];
	wire serial_in_line_s = pin_s2_r[2];
	wire hwrst_s = pin_s2_r[3];
	// Edges found by oversampling; 20 MHz leaves five clocks per phase
	wire sclk_fall = sclk_d_r & ~sclk_s;
	wire sclk_rise = ~sclk_d_r & sclk_s;
	wire shift_w   = sclk_fall & ~sen_n_s;

	// Serial shifter state
	logic [3:0]  bit_cnt_r;
	logic [14:0] shreg_r;
	logic [7:0]  rb_shift_r;
	logic [7:0]  cfg_r [256];
	logic [1:0]  ctrl_r;
	logic [15:0] words_r;
	logic [7:0]  last_addr_r;
	logic        rb_mode_r;
	logic        strap_r;
	logic [7:0]  strap_cnt_r;

	// Word decode: address in the upper byte, MSB first
	wire [15:0] word_w      = {shreg_r, serial_in_line_s};
	wire [7:0]  word_addr_w = word_w[15:8];
	wire [7:0]  word_data_w = word_w[7:0];
	wire        commit_w    = shift_w & (bit_cnt_r == ascp_pkg::LAST_BIT)
	                          & ctrl_r[ascp_pkg::AV_CTRL_PORTEN];
	wire        addr0_w     = (word_addr_w == ascp_pkg::CFG_CTL_ADDR);
	wire        wr_en_w     = commit_w & (~rb_mode_r | addr0_w);
	wire        sw_rst_w    = wr_en_w & addr0_w
	                          & word_data_w[ascp_pkg::CTL_SWRST_BIT];
	wire        av_swrst_w;
	wire        defaults_w  = hwrst_s | sw_rst_w | av_swrst_w;
	// Readback source: address zero reads as zero
	wire [7:0]  rb_addr_w   = {shreg_r[6:0], serial_in_line_s};
	wire        rb_load_w   = shift_w & rb_mode_r
	                          & (bit_cnt_r == (ascp_pkg::ADDR_DONE - 4'h1));
	wire [7:0]  rb_data_w   = (rb_addr_w == ascp_pkg::CFG_CTL_ADDR) ?
	                          ascp_pkg::CFG_ZERO : cfg_r[rb_addr_w];
	wire        rb_shift_w  = sclk_rise & ~sen_n_s & rb_mode_r
	                          & (bit_cnt_r >= ascp_pkg::DATA_FIRST);

	// Bit counter wraps every word; enable high discards partial words
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			bit_cnt_r <= 4'h0;
			shreg_r   <= 15'h0000;
		end else if (sen_n_s) begin
			bit_cnt_r <= 4'h0;
		end else if (shift_w) begin
			bit_cnt_r <= bit_cnt_r + 4'h1;
			shreg_r   <= word_w[14:0];
		end
	end

	// Register file: reset and soft reset beat serial writes
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < 256; i++)
				cfg_r[i] <= ascp_pkg::CFG_ZERO;
			cfg_r[ascp_pkg::CFG_GAIN_ADDR] <= ascp_pkg::CFG_GAIN_DFLT;
			cfg_r[ascp_pkg::CFG_CLK_ADDR]  <= ascp_pkg::CFG_CLK_DFLT;
		end else if (defaults_w || strap_r) begin
			for (int i = 0; i < 256; i++)
				cfg_r[i] <= ascp_pkg::CFG_ZERO;
			cfg_r[ascp_pkg::CFG_GAIN_ADDR] <= ascp_pkg::CFG_GAIN_DFLT;
			cfg_r[ascp_pkg::CFG_CLK_ADDR]  <= ascp_pkg::CFG_CLK_DFLT;
		end else if (wr_en_w) begin
			cfg_r[word_addr_w] <= addr0_w ?
				{7'h00, word_data_w[ascp_pkg::CTL_RBACK_BIT]} : word_data_w;
		end
	end
	// Readback mode mirrors bit 0 of address zero
	assign rb_mode_r = cfg_r[ascp_pkg::CFG_CTL_ADDR][ascp_pkg::CTL_RBACK_BIT];

	// Readback shifter: D7 after address, next bit on each rising edge from the tenth bit on
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			rb_shift_r <= 8'h00;
		else if (rb_load_w)
			rb_shift_r <= rb_data_w;
		else if (rb_shift_w)
			rb_shift_r <= {rb_shift_r[6:0], 1'b0};
	end

	// Shared pin: over-range unless readback mode is on
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			overrange_or_readback_pin <= 1'b0;
		else if (rb_mode_r)
			overrange_or_readback_pin <= rb_load_w ? rb_data_w[7]
			                             : rb_shift_r[7];
		else
			overrange_or_readback_pin <= overrange_in;
	end

	// Reset pin held past 1 us means strapped configuration
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			strap_cnt_r <= 8'h00;
			strap_r     <= 1'b0;
		end else if (!hwrst_s) begin
			strap_cnt_r <= 8'h00;
			strap_r     <= 1'b0;
		end else if (strap_cnt_r == 8'(ascp_pkg::STRAP_CYCLES)) begin
			strap_r     <= 1'b1;
		end else begin
			strap_cnt_r <= strap_cnt_r + 8'h01;
		end
	end

	// Static pin functions; level codes come from an outside comparator
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			fmt_offset_binary <= 1'b0;
			fmt_cmos          <= 1'b0;
			out_buffers_en    <= 1'b0;
			standby           <= 1'b0;
		end else begin
			fmt_offset_binary <= pin_s2_r[4 + ascp_pkg::FMT_LVL_HI];
			fmt_cmos          <= pin_s2_r[4 + ascp_pkg::FMT_LVL_HI]
			                     ^ pin_s2_r[4 + ascp_pkg::FMT_LVL_LO];
			out_buffers_en    <= pin_s2_r[6];
			standby           <= strap_r & serial_in_line_s;
		end
	end

	// Avalon slave: one wait state, answer on the second cycle
	logic        ack_r;
	logic [31:0] rdata_r;
	wire         av_req_w  = avs_read | avs_write;
	wire         av_wr_w   = avs_write & ack_r;
	wire         av_ctrl_w = av_wr_w & (avs_address == ascp_pkg::AV_CTRL);
	wire         av_cfg_w  = (avs_address[11:10] == ascp_pkg::AV_CFG_WIN);
	wire [31:0]  status_w  = {16'h0000, last_addr_r, 4'h0, standby,
	                          overrange_or_readback_pin, strap_r, rb_mode_r};
	wire [31:0]  rmux_w    =
		(avs_address == ascp_pkg::AV_STATUS) ? status_w :
		(avs_address == ascp_pkg::AV_CTRL)   ? {30'h0, ctrl_r} :
		(avs_address == ascp_pkg::AV_WORDS)  ? {16'h0000, words_r} :
		av_cfg_w ? {24'h000000, cfg_r[avs_address[9:2]]} : 32'h00000000;
	assign av_swrst_w      = av_ctrl_w & avs_writedata[ascp_pkg::AV_CTRL_SWRST];
	assign avs_waitrequest = av_req_w & ~ack_r;
	assign avs_readdata    = rdata_r;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ack_r   <= 1'b0;
			rdata_r <= 32'h00000000;
			ctrl_r  <= ascp_pkg::AV_CTRL_RESET;
		end else begin
			ack_r <= av_req_w & ~ack_r;
			if (avs_read && !ack_r)
				rdata_r <= rmux_w;
			if (av_ctrl_w)
				ctrl_r <= {avs_writedata[ascp_pkg::AV_CTRL_PORTEN], 1'b0};
		end
	end

	// Activity counters for software
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			words_r     <= 16'h0000;
			last_addr_r <= 8'h00;
		end else if (commit_w) begin
			words_r     <= words_r + 16'h0001;
			last_addr_r <= word_addr_w;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	idle_clears_cnt_a: assert property (
		sen_n_s |=> bit_cnt_r == 4'h0)
		else $error("bit count not cleared while enable high");
	sample_fall_a: assert property (
		shift_w && !defaults_w |=> shreg_r[0] == $past(serial_in_line_s))
		else $error("serial bit not taken on falling edge");
	commit_word_a: assert property (
		wr_en_w && !addr0_w && !defaults_w && !strap_r
		|=> cfg_r[$past(word_addr_w)] == $past(word_data_w))
		else $error("sixteen-bit word not committed");
	partial_drop_a: assert property (
		sen_n_s |=> $stable(words_r) && $stable(last_addr_r))
		else $error("word committed while enable high");
	rb_block_a: assert property (
		rb_mode_r && commit_w && !addr0_w |-> !wr_en_w)
		else $error("write passed in readback mode");
	soft_reset_a: assert property (
		sw_rst_w |=> cfg_r[ascp_pkg::CFG_CTL_ADDR] == ascp_pkg::CFG_ZERO
		&& cfg_r[ascp_pkg::CFG_GAIN_ADDR] == ascp_pkg::CFG_GAIN_DFLT)
		else $error("soft reset did not restore defaults");
	hw_reset_a: assert property (
		hwrst_s |=> cfg_r[ascp_pkg::CFG_CLK_ADDR] == ascp_pkg::CFG_CLK_DFLT)
		else $error("reset pin did not restore defaults");
	rb_first_bit_a: assert property (
		rb_load_w |=> overrange_or_readback_pin == $past(rb_data_w[7])
		&& rb_shift_r == $past(rb_data_w))
		else $error("readback MSB not driven after address");
	ovr_pin_a: assert property (
		!rb_mode_r ##1 !rb_mode_r |-> overrange_or_readback_pin
		== $past(overrange_in))
		else $error("pin not following over-range");
	strap_standby_a: assert property (
		strap_r && serial_in_line_s |=> standby)
		else $error("standby not set in strapped mode");

	// Bookkeeping checks on words, readback shifting and the bus
	word_count_a: assert property (
		commit_w |=> words_r == $past(words_r) + 16'h0001)
		else $error("committed word not counted");
	swrst_clear_a: assert property (
		sw_rst_w |=>
		!cfg_r[ascp_pkg::CFG_CTL_ADDR][ascp_pkg::CTL_SWRST_BIT])
		else $error("soft reset bit did not clear");
	addr0_keep_a: assert property (
		wr_en_w && addr0_w && !defaults_w && !strap_r |=> cfg_r[0] ==
		{7'h00, $past(word_data_w[ascp_pkg::CTL_RBACK_BIT])})
		else $error("address zero stored more than readback bit");
	rb_step_a: assert property (
		rb_shift_w && !rb_load_w
		|=> rb_shift_r == {$past(rb_shift_r[6:0]), 1'b0})
		else $error("readback bit not advanced on rising edge");
	rb_addr0_a: assert property (
		rb_load_w && rb_addr_w == ascp_pkg::CFG_CTL_ADDR
		|=> !overrange_or_readback_pin && rb_shift_r == ascp_pkg::CFG_ZERO)
		else $error("address zero content was read back");
	// The slave answers every request after exactly one wait state
	wait_once_a: assert property (
		avs_waitrequest |=> !avs_waitrequest)
		else $error("more than one wait state on the bus");
endmodule : ascp_serial_port
`default_nettype wire

// File: hdl/ascp_dummy_unused.sv
// Holds no logic: the port logic sits in the serial port file and its constants in the package.

// File: tb/ascp_host_model.sv
// Host controller model for the serial configuration pins.
// Assumes the bench calls its tasks; shift clock period is 48 ns.
`timescale 1ns/1ps
`default_nettype none
module ascp_host_model (
	output logic      sen_n,
	output logic      sclk,
	output logic      sdin,
	input  wire logic sdout
);
	logic [7:0] rx;
	// Board idle levels: enable high, clock parked low between frames
	initial begin
		sen_n = 1'h1;
		sclk  = 1'h0;
		sdin  = 1'h0;
		rx    = 8'h00;
	end
	// Data moves on the rise, so it sits 24 ns either side of each fall
	task automatic shift_bit(input logic b);
		sclk = 1'h1;
		sdin = b;
		#24 sclk = 1'h0;
		rx = {rx[6:0], sdout};
		#24;
	endtask : shift_bit
	// Address then data, most significant bit first
	task automatic word(input logic [15:0] w);
		for (int i = 15; i >= 0; i--) begin
			shift_bit(w[i]);
		end
	endtask : word
	// Enable edges keep over 25 ns from any shift clock fall
	task automatic frame_on();
		sen_n = 1'h0;
		#26;
	endtask : frame_on
	task automatic frame_off();
		#2 sen_n = 1'h1;
		#100;
	endtask : frame_off
	// Strap level on the data line while the port is unused
	task automatic set_line(input logic b);
		sdin = b;
	endtask : set_line
endmodule : ascp_host_model
`default_nettype wire

// File: tb/ascp_serial_port_bench.sv
// Self-checking bench for the serial configuration port.
// Assumes the host model is compiled first; reads are queued and checked.
`timescale 1ns/1ps
`default_nettype none
module ascp_serial_port_bench;
	localparam logic [7:0] CTL  = ascp_pkg::CFG_CTL_ADDR;
	localparam logic [7:0] GAIN = ascp_pkg::CFG_GAIN_ADDR;
	localparam logic [7:0] CLKR = ascp_pkg::CFG_CLK_ADDR;
	logic        clk = 1'h0;
	logic        nrst = 1'h0;
	logic [11:0] avs_address = 12'h000;
	logic        avs_read = 1'h0;
	logic        avs_write = 1'h0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        reset_pin = 1'h0;
	logic [1:0]  format_select_pin = 2'h0;
	logic        output_enable_pin = 1'h0;
	logic        overrange_in = 1'h0;
	logic        pin, fmt_ob, fmt_cmos, obuf_en, standby;
	wire         sen_n, sclk, sdin;
	logic [31:0] exp_q[$];
	logic [7:0]  dg, dc;
	int          n_mismatch = 0;
	int          num_checks = 0;
	always #2.5 clk = ~clk;
	ascp_serial_port u_ascp_serial_port (.clk(clk), .nrst(nrst),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.serial_enable_n(sen_n), .serial_clk(sclk), .serial_in_line(sdin),
		.reset_pin(reset_pin), .format_select_pin(format_select_pin),
		.output_enable_pin(output_enable_pin), .overrange_in(overrange_in),
		.overrange_or_readback_pin(pin), .fmt_offset_binary(fmt_ob),
		.fmt_cmos(fmt_cmos), .out_buffers_en(obuf_en), .standby(standby));
	ascp_host_model u_ascp_host_model (.sen_n(sen_n), .sclk(sclk),
		.sdin(sdin), .sdout(pin));
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	// Hold the request until waitrequest is seen low at a rising edge
	// Only the watchdog ends a wait that never gets an answer
	task automatic av_wait();
		do begin
			@(posedge clk);
		end while (avs_waitrequest !== 1'h0);
		avs_read  <= 1'h0;
		avs_write <= 1'h0;
	endtask : av_wait
	task automatic av_rd(input logic [11:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		@(posedge clk);
		avs_address <= a;
		avs_read    <= 1'h1;
		av_wait();
	endtask : av_rd
	task automatic av_wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		avs_address   <= a;
		avs_writedata <= d;
		avs_write     <= 1'h1;
		av_wait();
	endtask : av_wr
	function automatic logic [11:0] cfg(input logic [7:0] a);
		return {ascp_pkg::AV_CFG_WIN, a, 2'h0};
	endfunction : cfg
	task automatic send(input logic [15:0] w);
		u_ascp_host_model.frame_on();
		u_ascp_host_model.word(w);
		u_ascp_host_model.frame_off();
	endtask : send
	// Each accepted read takes the oldest queued expectation
	always @(posedge clk) begin
		if (avs_read === 1'h1 && avs_waitrequest === 1'h0) begin
			chk(avs_readdata, exp_q.pop_front());
		end
	end
	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : complete_run
	// A whole run is about thirteen microseconds
	initial begin
		#200000;
		n_mismatch++;
		complete_run();
	end
	initial begin
		void'($urandom(55));
		repeat (3) @(posedge clk);
		nrst <= 1'h1;
		repeat (3) @(posedge clk);
		av_rd(cfg(GAIN), 32'(ascp_pkg::CFG_GAIN_DFLT));
		av_rd(ascp_pkg::AV_CTRL, 32'h2);
		av_wr(12'h0FC, 32'hFFFFFFFF);
		av_rd(12'h0FC, 32'h0);
		u_ascp_host_model.word({GAIN, 8'hFF});
		av_rd(cfg(GAIN), 32'(ascp_pkg::CFG_GAIN_DFLT));
		$display("test defaults done");
		// Two words and a five-bit tail in one frame
		dg = 8'($urandom);
		dc = 8'($urandom);
		u_ascp_host_model.frame_on();
		u_ascp_host_model.word({GAIN, dg});
		u_ascp_host_model.word({CLKR, dc});
		for (int i = 0; i < 5; i++) u_ascp_host_model.shift_bit(1'h1);
		u_ascp_host_model.frame_off();
		av_rd(cfg(GAIN), 32'(dg));
		av_rd(cfg(CLKR), 32'(dc));
		av_rd(ascp_pkg::AV_WORDS, 32'h2);
		$display("test writes done");
		// Readback with blocked writes, then leave the mode
		u_ascp_host_model.frame_on();
		u_ascp_host_model.word({CTL, 8'h01});
		u_ascp_host_model.word({GAIN, 8'h00});
		chk(32'(u_ascp_host_model.rx), 32'(dg));
		u_ascp_host_model.word({CTL, 8'h01});
		chk(32'(u_ascp_host_model.rx), 32'h0);
		u_ascp_host_model.word({CLKR, ~dc});
		chk(32'(u_ascp_host_model.rx), 32'(dc));
		u_ascp_host_model.word({CTL, 8'h00});
		u_ascp_host_model.frame_off();
		av_rd(cfg(GAIN), 32'(dg));
		av_rd(cfg(CLKR), 32'(dc));
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			overrange_in <= i[0];
			repeat (2) @(negedge clk);
			chk(32'(pin), 32'(i[0]));
		end
		send({CLKR, dg});
		av_rd(cfg(CLKR), 32'(dg));
		$display("test readback done");
		// Software and hardware reset
		send({CTL, 8'h02});
		av_rd(cfg(GAIN), 32'(ascp_pkg::CFG_GAIN_DFLT));
		av_rd(cfg(CLKR), 32'(ascp_pkg::CFG_CLK_DFLT));
		av_rd(cfg(CTL), 32'h0);
		send({GAIN, ~ascp_pkg::CFG_GAIN_DFLT});
		@(posedge clk);
		reset_pin <= 1'h1;
		repeat (3) @(posedge clk);
		reset_pin <= 1'h0;
		#100;
		av_rd(cfg(GAIN), 32'(ascp_pkg::CFG_GAIN_DFLT));
		// Soft reset from the bus, then a disabled port drops words
		send({GAIN, 8'h00});
		av_wr(ascp_pkg::AV_CTRL, 32'h3);
		av_rd(cfg(GAIN), 32'(ascp_pkg::CFG_GAIN_DFLT));
		av_rd(ascp_pkg::AV_CTRL, 32'h2);
		av_wr(ascp_pkg::AV_CTRL, 32'h0);
		send({GAIN, 8'h00});
		av_rd(cfg(GAIN), 32'(ascp_pkg::CFG_GAIN_DFLT));
		av_wr(ascp_pkg::AV_CTRL, 32'h2);
		$display("test resets done");
		// Strapped standby, then the format and output enable pins
		u_ascp_host_model.set_line(1'h1);
		@(posedge clk);
		reset_pin <= 1'h1;
		repeat (250) @(negedge clk);
		chk(32'(standby), 32'h1);
		u_ascp_host_model.set_line(1'h0);
		repeat (6) @(negedge clk);
		chk(32'(standby), 32'h0);
		// Status: last address 0x25, pin high, strap on, standby off
		av_rd(ascp_pkg::AV_STATUS, {16'h0000, GAIN, 8'h06});
		@(posedge clk);
		reset_pin <= 1'h0;
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			format_select_pin <= 2'(i);
			output_enable_pin <= 1'($urandom);
			repeat (6) @(negedge clk);
			chk(32'({fmt_ob, fmt_cmos}), 32'({i[1], i[1] ^ i[0]}));
			chk(32'(obuf_en), 32'(output_enable_pin));
		end
		$display("test pins done");
		complete_run();
	end
endmodule : ascp_serial_port_bench
`default_nettype wire
